//--- verilog/rlc_pkg.sv
// constants and types for the radio link configuration control block
package rlc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_ROLE = 8'h41, IDX_IDOPT = 8'h45, IDX_BCNT = 8'h4d;
    localparam logic [7:0] IDX_NETA = 8'h56, IDX_NETB = 8'h57, IDX_OVR = 8'h5b;
    localparam logic [7:0] IDX_SLP = 8'h61, IDX_PWR = 8'h63, IDX_SKIP = 8'h6f;
    localparam logic [7:0] IDX_DST0 = 8'h75, IDX_DST4 = 8'h79, IDX_ROPT = 8'hc1;
    localparam logic [7:0] IDX_REFR = 8'hd0, IDX_SPER = 8'hd1, IDX_WPER = 8'hd2;
    localparam logic [7:0] IDX_LOPT = 8'hd3, IDX_STAT = 8'hd4;
    // storage slots
    localparam logic [4:0] S_ROLE = 5'h00, S_IDOPT = 5'h01, S_BCNT = 5'h02, S_NETA = 5'h03;
    localparam logic [4:0] S_NETB = 5'h04, S_OVR = 5'h05, S_SLP = 5'h06, S_PWR = 5'h07;
    localparam logic [4:0] S_SKIP = 5'h08, S_DST0 = 5'h09, S_ROPT = 5'h0e, S_REFR = 5'h0f;
    localparam logic [4:0] S_SPER = 5'h10, S_WPER = 5'h11, S_LOPT = 5'h12;
    localparam int NSLOT = 19;
    // field positions
    localparam int B_ANT = 5, B_BCAST = 7, B_NOSTAT = 4;
    localparam int B_ACFG = 0, B_DUPLEX = 1, B_ACHAN = 3, B_ADST = 4, B_ABCN = 7;
    localparam int B_ASYS = 4, B_LEG = 2;
    localparam int B_HOPD = 6, B_FERR = 7;
    localparam int B_CSLP = 0, B_TXAPI = 0;
    // values after reset and fixed figures
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_REFR = 8'h01;
    localparam logic [7:0] ROLE_SERVER = 8'h02;
    localparam logic [7:0] LEGACY_ADD = 8'h80;
    localparam logic [8:0] BCAST_ZERO = 9'h100;
    localparam logic [7:0] HOPD_MIN = 8'h06;
    localparam logic [7:0] PWR_STEP_DB = 8'h03;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // sleep cycle states
    typedef enum logic [1:0] {
        RLC_AWAKE = 2'h0,
        RLC_ASLEEP = 2'h1
    } rlc_slp_t;
endpackage

//--- verilog/rlc_top.sv
// radio link configuration registers and the control logic they steer
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
module rlc_top
    import rlc_pkg::*;
#(
    parameter int TW = 16
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic force_pin,
    input wire logic hop_start,
    input wire logic slot_start,
    input wire logic slot_srv,
    input wire logic srv_busy,
    input wire logic srv_seen,
    input wire logic srv_chan_ok,
    input wire logic srv_id_ok,
    input wire logic bcn_rx,
    input wire logic rx_ok,
    input wire logic [31:0] rx_src,
    input wire logic rx_bc,
    input wire logic rx_err,
    input wire logic [7:0] rx_seq,
    input wire logic tx_req,
    input wire logic buf_rdy,
    input wire logic buf_ferr,
    input wire logic [7:0] ser_cnt,
    input wire logic [7:0] rssi_in,
    input wire logic tick,
    input wire logic [7:0] def_gap,
    input wire logic [7:0] def_size,
    input wire logic [7:0] ee_gap,
    input wire logic [7:0] ee_size,
    output logic ant_ext,
    output logic srv_mode,
    output logic bcn_send,
    output logic bcn_listen,
    output logic hop_align,
    output logic sync_ok,
    output logic [31:0] dst_out,
    output logic dst_use,
    output logic tx_fire,
    output logic tx_done,
    output logic rx_fwd,
    output logic buf_drop,
    output logic buf_take,
    output logic pkt_close,
    output logic stat_rx,
    output logic [7:0] rssi_out,
    output logic [7:0] atten_db,
    output logic [7:0] gap_to,
    output logic [7:0] pkt_size,
    output logic radio_on
);
    typedef struct packed {
        logic [NSLOT-1:0][7:0] rf;
        logic ap;
        logic aw;
        logic [4:0] as;
        logic am;
        logic [31:0] hrdata;
        logic hreadyout;
        logic f1;
        logic f2;
        logic [7:0] hcnt;
        logic [8:0] left;
        logic busy;
        logic [7:0] lseq;
        logic lval;
        logic [31:0] lrn;
        logic ldst;
        rlc_slp_t sst;
        logic [TW-1:0] tcnt;
        logic closed;
        logic ant_ext;
        logic srv_mode;
        logic bcn_send;
        logic bcn_listen;
        logic hop_align;
        logic sync_ok;
        logic [31:0] dst_out;
        logic dst_use;
        logic tx_fire;
        logic tx_done;
        logic rx_fwd;
        logic buf_drop;
        logic buf_take;
        logic pkt_close;
        logic stat_rx;
        logic [7:0] rssi_out;
        logic [7:0] atten_db;
        logic [7:0] gap_to;
        logic [7:0] pkt_size;
        logic radio_on;
    } rlc_st_t;

    rlc_st_t s;
    rlc_st_t next_s;

    // byte index to storage slot, msb flags a hit
    function automatic logic [5:0] rlc_dec(input logic [7:0] idx);
        logic [5:0] r;
        r = 6'h00;
        case (idx)
            IDX_ROLE: r = {1'b1, S_ROLE};
            IDX_IDOPT: r = {1'b1, S_IDOPT};
            IDX_BCNT: r = {1'b1, S_BCNT};
            IDX_NETA: r = {1'b1, S_NETA};
            IDX_NETB: r = {1'b1, S_NETB};
            IDX_OVR: r = {1'b1, S_OVR};
            IDX_SLP: r = {1'b1, S_SLP};
            IDX_PWR: r = {1'b1, S_PWR};
            IDX_SKIP: r = {1'b1, S_SKIP};
            IDX_ROPT: r = {1'b1, S_ROPT};
            IDX_REFR: r = {1'b1, S_REFR};
            IDX_SPER: r = {1'b1, S_SPER};
            IDX_WPER: r = {1'b1, S_WPER};
            IDX_LOPT: r = {1'b1, S_LOPT};
            default:
            begin
                if (idx >= IDX_DST0 && idx <= IDX_DST4)
                    r = {1'b1, 5'(idx - IDX_DST0) + S_DST0};
            end
        endcase
        return r;
    endfunction

    // decoded configuration fields
    logic is_srv, bcast, adst, abcn, txapi, duplex, cyc, hopd, ferr_en;
    logic grant;
    logic [5:0] dec;
    logic [7:0] rv;
    assign is_srv = s.rf[S_ROLE] == ROLE_SERVER;
    assign bcast = s.rf[S_ROPT][B_BCAST];
    assign adst = s.rf[S_NETA][B_ADST];
    assign abcn = s.rf[S_NETA][B_ABCN];
    assign txapi = s.rf[S_LOPT][B_TXAPI];
    assign duplex = s.rf[S_NETA][B_DUPLEX];
    assign cyc = s.rf[S_SLP][B_CSLP];
    assign hopd = s.rf[S_NETB][B_HOPD];
    assign ferr_en = s.rf[S_NETB][B_FERR];
    assign dec = rlc_dec(haddr[9:2]);
    // duplex slot ownership
    assign grant = !duplex || (is_srv ? slot_srv : (!slot_srv || !srv_busy));

    // read value, forwarding a write still in its data phase
    always_comb
    begin
        rv = 8'h00;
        if (haddr[9:2] == IDX_STAT)
            rv = {4'h0, s.ldst, s.lval, s.busy, s.sst == RLC_ASLEEP};
        else if (dec[5] && s.ap && s.aw && s.am && s.as == dec[4:0])
            rv = hwdata[7:0];
        else if (dec[5])
            rv = s.rf[dec[4:0]];
    end

    // next state of the whole block
    always_comb
    begin
        next_s = s;
        next_s.bcn_send = 1'b0;
        next_s.hop_align = 1'b0;
        next_s.sync_ok = 1'b0;
        next_s.tx_fire = 1'b0;
        next_s.tx_done = 1'b0;
        next_s.rx_fwd = 1'b0;
        next_s.buf_drop = 1'b0;
        next_s.buf_take = 1'b0;
        next_s.pkt_close = 1'b0;
        // bus data phase write, then address phase capture
        if (s.ap && s.aw && s.am)
            next_s.rf[s.as] = hwdata[7:0];
        next_s.ap = hsel && htrans == HTRANS_NONSEQ && hready && hsize == HSIZE_WORD;
        next_s.aw = hwrite;
        next_s.as = dec[4:0];
        next_s.am = dec[5] && haddr[11:10] == 2'h0;
        if (next_s.ap && !hwrite)
            next_s.hrdata = {24'h000000, (dec[5] || haddr[9:2] == IDX_STAT) && haddr[11:10] == 2'h0 ? rv : 8'h00};
        next_s.hreadyout = 1'b1;
        // override pin synchroniser
        next_s.f1 = force_pin;
        next_s.f2 = s.f1;
        // static steering
        next_s.ant_ext = s.rf[S_OVR] != 8'h00 || s.rf[S_ROPT][B_ANT];
        next_s.srv_mode = is_srv;
        next_s.stat_rx = !s.rf[S_ROPT][B_NOSTAT];
        next_s.rssi_out = rssi_in + (s.rf[S_IDOPT][B_LEG] ? LEGACY_ADD : 8'h00);
        next_s.atten_db = 8'(s.rf[S_PWR] * PWR_STEP_DB);
        next_s.gap_to = s.rf[S_NETA][B_ACFG] ? def_gap : ee_gap;
        next_s.pkt_size = s.rf[S_NETA][B_ACFG] ? def_size : ee_size;
        // server acceptance
        if (srv_seen && !is_srv)
        begin
            if (s.rf[S_IDOPT][B_ASYS])
                next_s.sync_ok = srv_chan_ok;
            else
                next_s.sync_ok = srv_id_ok && (s.rf[S_NETA][B_ACHAN] || srv_chan_ok);
        end
        // beacon spacing per hop
        if (hop_start)
        begin
            if (is_srv)
            begin
                next_s.bcn_send = s.hcnt == 8'h00;
                if (s.hcnt == 8'h00)
                    next_s.hcnt = s.rf[S_SKIP] == 8'h00 ? 8'h00 : s.rf[S_SKIP] - 8'h01;
                else
                    next_s.hcnt = s.hcnt - 8'h01;
            end
            else if (s.hcnt != 8'h00)
                next_s.hcnt = s.hcnt - 8'h01;
        end
        if (bcn_rx && !is_srv)
        begin
            next_s.hop_align = 1'b1;
            next_s.hcnt = s.rf[S_SKIP] == 8'h00 ? 8'h00 : s.rf[S_REFR];
        end
        next_s.bcn_listen = !is_srv && next_s.hcnt == 8'h00;
        // destination learning
        if (rx_ok && adst && (!abcn || bcn_rx))
        begin
            next_s.lrn = rx_src;
            next_s.ldst = 1'b1;
        end
        next_s.dst_out = adst ? s.lrn : {s.rf[S_DST0+5'h03], s.rf[S_DST0+5'h02],
            s.rf[S_DST0+5'h01], s.rf[S_DST0]};
        next_s.dst_use = !(bcast || txapi) && (!adst || s.ldst);
        // transmit attempts
        if (tx_req && !s.busy)
        begin
            next_s.busy = 1'b1;
            if (!bcast)
                next_s.left = 9'h001;
            else if (s.rf[S_BCNT] == 8'h00)
                next_s.left = BCAST_ZERO;
            else
                next_s.left = {1'b0, s.rf[S_BCNT]};
        end
        else if (s.busy && slot_start && grant)
        begin
            next_s.tx_fire = 1'b1;
            next_s.left = s.left - 9'h001;
            if (s.left == 9'h001)
            begin
                next_s.busy = 1'b0;
                next_s.tx_done = 1'b1;
            end
        end
        // broadcast receive filter
        if (rx_bc && rx_ok && !rx_err && !(s.lval && rx_seq == s.lseq))
        begin
            next_s.rx_fwd = 1'b1;
            next_s.lseq = rx_seq;
            next_s.lval = 1'b1;
        end
        // serial buffer check
        if (buf_rdy)
        begin
            next_s.buf_drop = ferr_en && buf_ferr;
            next_s.buf_take = !(ferr_en && buf_ferr);
        end
        // hop delineation
        if (hop_start)
            next_s.closed = 1'b0;
        if (hopd && (!s.closed || hop_start) && ser_cnt >= HOPD_MIN)
        begin
            next_s.pkt_close = 1'b1;
            next_s.closed = 1'b1;
        end
        // cyclic sleep
        case (s.sst)
            RLC_AWAKE:
            begin
                if (!cyc || next_s.tx_fire)
                    next_s.tcnt = '0;
                else if (tick && s.tcnt >= TW'(s.rf[S_WPER]))
                begin
                    next_s.sst = RLC_ASLEEP;
                    next_s.tcnt = '0;
                end
                else if (tick)
                    next_s.tcnt = s.tcnt + TW'(1);
            end
            RLC_ASLEEP:
            begin
                if (s.f2 || !cyc || (tick && s.tcnt >= TW'(s.rf[S_SPER])))
                begin
                    next_s.sst = RLC_AWAKE;
                    next_s.tcnt = '0;
                end
                else if (tick)
                    next_s.tcnt = s.tcnt + TW'(1);
            end
            default:
            begin
                next_s.sst = RLC_AWAKE;
                next_s.tcnt = '0;
            end
        endcase
        next_s.radio_on = next_s.sst == RLC_AWAKE;
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0;
            s.rf[S_REFR] <= RST_REFR;
            s.hreadyout <= 1'b1;
            s.stat_rx <= 1'b1;
            s.radio_on <= 1'b1;
            s.sst <= RLC_AWAKE;
        end
        else if (ce)
            s <= next_s;
    end

    // outputs straight from the state register, except hresp which is tied to okay
    assign hrdata = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp = 1'b0;
    assign ant_ext = s.ant_ext;
    assign srv_mode = s.srv_mode;
    assign bcn_send = s.bcn_send;
    assign bcn_listen = s.bcn_listen;
    assign hop_align = s.hop_align;
    assign sync_ok = s.sync_ok;
    assign dst_out = s.dst_out;
    assign dst_use = s.dst_use;
    assign tx_fire = s.tx_fire;
    assign tx_done = s.tx_done;
    assign rx_fwd = s.rx_fwd;
    assign buf_drop = s.buf_drop;
    assign buf_take = s.buf_take;
    assign pkt_close = s.pkt_close;
    assign stat_rx = s.stat_rx;
    assign rssi_out = s.rssi_out;
    assign atten_db = s.atten_db;
    assign gap_to = s.gap_to;
    assign pkt_size = s.pkt_size;
    assign radio_on = s.radio_on;

    // checks on the block's own behaviour
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_ovr;
        ce && s.rf[S_OVR] != 8'h00 |=> ant_ext;
    endproperty
    a_ovr: assert property (p_ovr) else $error("override did not force external antenna");

    property p_zero;
        ce && tx_req && !s.busy && bcast && s.rf[S_BCNT] == 8'h00 |=> s.left == 9'h100 && s.busy;
    endproperty
    a_zero: assert property (p_zero) else $error("zero attempts not taken as 256");

    property p_fire;
        tx_fire |-> $past(s.busy) && $past(slot_start);
    endproperty
    a_fire: assert property (p_fire) else $error("send outside a pending slot");

    property p_dup;
        ce && rx_bc && rx_ok && s.lval && rx_seq == s.lseq |=> !rx_fwd;
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate broadcast forwarded");

    property p_ferr;
        ce && buf_rdy && ferr_en && buf_ferr |=> buf_drop && !buf_take;
    endproperty
    a_ferr: assert property (p_ferr) else $error("errored buffer not discarded");

    property p_hop;
        ce && pkt_close ##1 ce && !hop_start |=> !pkt_close;
    endproperty
    a_hop: assert property (p_hop) else $error("second close within one hop");

    property p_rssi;
        ce && s.rf[S_IDOPT][B_LEG] |=> rssi_out == $past(rssi_in) + 8'h80;
    endproperty
    a_rssi: assert property (p_rssi) else $error("legacy offset missing");

    property p_wake;
        ce && s.sst == RLC_ASLEEP && s.f2 |=> s.sst == RLC_AWAKE && radio_on;
    endproperty
    a_wake: assert property (p_wake) else $error("pin did not end sleep");

    property p_bar;
        ce && duplex && is_srv && slot_start && !slot_srv |=> !tx_fire;
    endproperty
    a_bar: assert property (p_bar) else $error("server sent in a client slot");

    property p_inact;
        tx_fire && s.sst == RLC_AWAKE |-> s.tcnt == '0;
    endproperty
    a_inact: assert property (p_inact) else $error("send did not restart wake time");

    property p_bonly;
        ce && rx_ok && adst && abcn && !bcn_rx |=> s.lrn == $past(s.lrn);
    endproperty
    a_bonly: assert property (p_bonly) else $error("learned from a non-beacon");
endmodule

//--- testbench/rlc_peer_model.sv
// peer radio model: received frames and server sightings seen by the block
`timescale 1ns/100ps
module rlc_peer_model
(
    input wire logic hclk,
    output logic bcn_rx,
    output logic rx_ok,
    output logic [31:0] rx_src,
    output logic rx_bc,
    output logic rx_err,
    output logic [7:0] rx_seq,
    output logic srv_seen,
    output logic srv_chan_ok,
    output logic srv_id_ok
);
    // idle: no events, payload lines carry a non-data pattern
    initial
    begin
        {bcn_rx, rx_ok, rx_bc, rx_err, srv_seen, srv_chan_ok, srv_id_ok} = '0;
        rx_src = 32'h5a5aa5a5;
        rx_seq = 8'h5a;
    end
    // one received frame; a broadcast copy repeats its copy id
    task send(input logic bcn, input logic bc, input logic err, input logic [7:0] seq, input logic [31:0] src);
        @(posedge hclk);
        bcn_rx <= bcn & ~err;
        rx_ok <= ~err;
        rx_bc <= bc;
        rx_err <= err;
        rx_seq <= seq;
        rx_src <= src;
        @(posedge hclk);
        {bcn_rx, rx_ok, rx_bc, rx_err} <= '0;
        rx_seq <= ~seq;
        rx_src <= ~src;
        repeat (2) @(posedge hclk);
    endtask
    // a server heard, with its channel and identity match flags
    task server(input logic chan, input logic id);
        @(posedge hclk);
        srv_seen <= 1'b1;
        srv_chan_ok <= chan;
        srv_id_ok <= id;
        @(posedge hclk);
        srv_seen <= 1'b0;
        srv_chan_ok <= ~chan;
        srv_id_ok <= ~id;
        repeat (2) @(posedge hclk);
    endtask
endmodule

//--- testbench/rlc_tb_top.sv
// self-checking bench for the radio link configuration control block
`timescale 1ns/100ps
module rlc_tb_top
    import rlc_pkg::*;
    ;
    logic hclk, hresetn, ce, hsel, hwrite, hready, force_pin, hop_start, slot_start, slot_srv, srv_busy;
    logic tx_req, buf_rdy, buf_ferr, tick, hreadyout, hresp, bcn_rx, rx_ok, rx_bc, rx_err;
    logic srv_seen, srv_chan_ok, srv_id_ok, ant_ext, srv_mode, bcn_send, bcn_listen, hop_align, sync_ok;
    logic dst_use, tx_fire, tx_done, rx_fwd, buf_drop, buf_take, pkt_close, stat_rx, radio_on;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rx_src, dst_out, seed, rd;
    logic [7:0] rx_seq, ser_cnt, rssi_in, def_gap, def_size, ee_gap, ee_size, rssi_out, atten_db, gap_to, pkt_size;
    logic [8:0] pv;
    int fails, tests_run, i, n, j;
    int cnt [9];
    int mreg [256];
    logic [7:0] ridx [19] = '{IDX_ROLE, IDX_IDOPT, IDX_BCNT, IDX_NETA, IDX_NETB, IDX_OVR, IDX_SLP, IDX_PWR,
        IDX_SKIP, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, IDX_ROPT, IDX_REFR, IDX_SPER, IDX_WPER, IDX_LOPT};
    assign hready = hreadyout;
    rlc_top #(.TW(8)) dut (.*);
    rlc_peer_model peer (.*);
    // clock
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // counts design pulses once they have settled
    always @(posedge hclk)
    begin
        #1;
        pv = {sync_ok, pkt_close, buf_take, buf_drop, rx_fwd, tx_done, tx_fire, hop_align, bcn_send};
        for (int k = 0; k < 9; k++)
            if (pv[k] === 1'b1)
                cnt[k]++;
    end
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one single-word transfer; the answer is taken when hready is seen high
    task ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {2'h0, idx, 2'h0};
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task wr(input logic [7:0] idx, input logic [31:0] v);
        ahb(1'b1, idx, v);
        mreg[idx] = int'(v[7:0]);
    endtask
    task rchk(input logic [7:0] idx);
        ahb(1'b0, idx, 32'h0);
        chk(rd, mreg[idx], "register");
    endtask
    task settle;
        repeat (3) @(posedge hclk);
        #1;
    endtask
    task clr;
        foreach (cnt[k]) cnt[k] = 0;
    endtask
    task hop;
        @(posedge hclk) hop_start <= 1'b1;
        @(posedge hclk) hop_start <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    task slot(input logic s, input logic b);
        @(posedge hclk);
        slot_start <= 1'b1;
        slot_srv <= s;
        srv_busy <= b;
        @(posedge hclk) slot_start <= 1'b0;
        @(posedge hclk);
    endtask
    task txr;
        @(posedge hclk) tx_req <= 1'b1;
        @(posedge hclk) tx_req <= 1'b0;
        @(posedge hclk);
    endtask
    task bufp(input logic f);
        @(posedge hclk);
        buf_rdy <= 1'b1;
        buf_ferr <= f;
        @(posedge hclk);
        buf_rdy <= 1'b0;
        buf_ferr <= ~f;
        @(posedge hclk);
    endtask
    // k sleep time units, one cycle each with a gap between
    task tk(input int k);
        repeat (k)
        begin
            @(posedge hclk) tick <= 1'b1;
            @(posedge hclk) tick <= 1'b0;
        end
    endtask
    // watchdog against a hang
    initial
    begin
        #200000;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict;
    end
    // main sequence
    initial
    begin
        {hsel, hwrite, force_pin, hop_start, slot_start, slot_srv, srv_busy, tx_req, buf_rdy, buf_ferr, tick} = '0;
        {haddr, htrans, hsize, hwdata, ser_cnt, rssi_in} = '0;
        {def_gap, def_size, ee_gap, ee_size} = 32'h11223344;
        hresetn = 1'b0;
        ce = 1'b1;
        seed = 32'hd9f5;
        foreach (mreg[k]) mreg[k] = 0;
        mreg[IDX_REFR] = 1;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (ridx[k]) rchk(ridx[k]);
        foreach (ridx[k])
        begin
            seed = lfsr(seed);
            wr(ridx[k], seed);
            rchk(ridx[k]);
        end
        foreach (ridx[k]) wr(ridx[k], 32'(ridx[k] == IDX_REFR));
        ahb(1'b1, 8'h00, seed);
        ahb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0, "unmapped");
        chk(hresp, 0, "okay response");
        ahb(1'b1, IDX_STAT, 32'hff);
        ahb(1'b0, IDX_STAT, 32'h0);
        chk(rd, 32'h0, "status");
        for (i = 0; i < 8; i++)
        begin
            wr(IDX_ROPT, ((i & 1) << B_ANT) | ((i & 4) << 2));
            wr(IDX_OVR, (i & 2) ? 32'h5a : 32'h0);
            settle;
            chk(ant_ext, 32'((i & 3) != 0), "antenna");
            chk(stat_rx, 32'((i & 4) == 0), "status slot");
        end
        for (i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            {rssi_in, ee_gap, def_size, ee_size} <= seed;
            def_gap <= seed[15:8] ^ 8'h5a;
            wr(IDX_IDOPT, (i & 1) << B_LEG);
            wr(IDX_NETA, (i >> 1) & 1);
            wr(IDX_PWR, seed[5:0]);
            settle;
            chk(rssi_out, 8'(seed[31:24] + ((i & 1) ? 8'h80 : 8'h00)), "strength");
            chk(atten_db, 8'(seed[5:0] * 3), "power");
            chk(gap_to, (i & 2) ? def_gap : ee_gap, "gap");
            chk(pkt_size, (i & 2) ? def_size : ee_size, "size");
        end
        for (i = 0; i < 16; i++)
        begin
            wr(IDX_NETA, (i & 1) << B_ACHAN);
            wr(IDX_IDOPT, (i & 2) << 3);
            clr;
            peer.server(i[2], i[3]);
            chk(cnt[8], 32'(i[1] ? i[2] : i[3] & (i[2] | i[0])), "sync");
        end
        wr(IDX_ROLE, ROLE_SERVER);
        wr(IDX_SKIP, 3);
        settle;
        chk(srv_mode, 1, "role");
        for (n = 3; n >= 0; n -= 3)
        begin
            wr(IDX_SKIP, n);
            clr;
            repeat (n == 3 ? 9 : 4) hop;
            chk(cnt[0], n == 3 ? 3 : 4, "beacons");
        end
        wr(IDX_ROLE, 0);
        clr;
        peer.send(1'b1, 1'b0, 1'b0, 8'h01, 32'h00000abc);
        chk(cnt[1], 1, "align");
        wr(IDX_SKIP, 2);
        wr(IDX_REFR, 2);
        peer.send(1'b1, 1'b0, 1'b0, 8'h01, 32'h00000abc);
        chk(bcn_listen, 0, "refresh wait");
        repeat (2) hop;
        chk(bcn_listen, 1, "hunt every hop");
        wr(IDX_NETA, 0);
        wr(IDX_IDOPT, 0);
        wr(IDX_ROPT, 0);
        for (i = 0; i < 5; i++) wr(8'(IDX_DST0 + i), 8'h11 * (i + 1));
        settle;
        chk(dst_out, 32'h44332211, "stored target");
        chk(dst_use, 1, "addressed");
        wr(IDX_NETA, 1 << B_ADST);
        peer.send(1'b1, 1'b0, 1'b0, 8'h02, 32'ha1a1a1a1);
        chk(dst_out, 32'ha1a1a1a1, "learn beacon");
        peer.send(1'b0, 1'b0, 1'b0, 8'h03, 32'hb2b2b2b2);
        chk(dst_out, 32'hb2b2b2b2, "learn data");
        wr(IDX_NETA, (1 << B_ADST) | (1 << B_ABCN));
        peer.send(1'b0, 1'b0, 1'b0, 8'h04, 32'hc3c3c3c3);
        chk(dst_out, 32'hb2b2b2b2, "beacons only");
        peer.send(1'b1, 1'b0, 1'b0, 8'h05, 32'hd4d4d4d4);
        chk(dst_out, 32'hd4d4d4d4, "beacons only");
        wr(IDX_NETA, 0);
        wr(IDX_ROPT, 1 << B_BCAST);
        settle;
        chk(dst_use, 0, "broadcast target");
        wr(IDX_ROPT, 0);
        wr(IDX_LOPT, 1);
        settle;
        chk(dst_use, 0, "packet mode target");
        wr(IDX_LOPT, 0);
        clr;
        peer.send(1'b0, 1'b1, 1'b1, 8'h05, 32'h1);
        peer.send(1'b0, 1'b1, 1'b0, 8'h05, 32'h1);
        peer.send(1'b0, 1'b1, 1'b0, 8'h05, 32'h1);
        peer.send(1'b0, 1'b1, 1'b0, 8'h06, 32'h1);
        chk(cnt[4], 2, "forwarded");
        ahb(1'b0, IDX_STAT, 32'h0);
        chk(rd, 32'h0000000c, "status flags");
        wr(IDX_ROPT, 1 << B_BCAST);
        for (n = 3; n >= 0; n -= 3)
        begin
            wr(IDX_BCNT, n);
            clr;
            txr;
            for (j = 0; j < 400 && cnt[3] == 0; j++) slot(1'b0, 1'b0);
            settle;
            chk(cnt[2], n == 0 ? 256 : n, "attempts");
            chk(cnt[3], 1, "done");
        end
        wr(IDX_BCNT, 1);
        wr(IDX_NETA, 1 << B_DUPLEX);
        clr;
        txr;
        repeat (3) slot(1'b1, 1'b1);
        settle;
        chk(cnt[2], 0, "client barred");
        slot(1'b0, 1'b1);
        txr;
        slot(1'b1, 1'b0);
        settle;
        chk(cnt[2], 2, "client slots");
        wr(IDX_ROLE, ROLE_SERVER);
        clr;
        txr;
        repeat (2) slot(1'b0, 1'b0);
        settle;
        chk(cnt[2], 0, "server barred");
        slot(1'b1, 1'b0);
        settle;
        chk(cnt[2], 1, "server slot");
        wr(IDX_ROLE, 0);
        wr(IDX_NETB, 1 << B_FERR);
        clr;
        bufp(1'b1);
        bufp(1'b0);
        wr(IDX_NETB, 1 << B_HOPD);
        bufp(1'b1);
        settle;
        chk(cnt[5], 1, "discard");
        chk(cnt[6], 2, "take");
        ser_cnt <= 8'h05;
        clr;
        repeat (2) hop;
        chk(cnt[7], 0, "short close");
        ser_cnt <= HOPD_MIN;
        repeat (3) hop;
        chk(cnt[7], 4, "hop close");
        wr(IDX_SPER, 8'hc8);
        wr(IDX_WPER, 2);
        wr(IDX_SLP, 1);
        tk(6);
        settle;
        chk(radio_on, 0, "asleep");
        force_pin <= 1'b1;
        repeat (5) @(posedge hclk);
        #1;
        chk(radio_on, 1, "woken");
        force_pin <= 1'b0;
        tk(2);
        txr;
        slot(1'b0, 1'b0);
        tk(2);
        settle;
        chk(radio_on, 1, "wake restarted by send");
        tk(1);
        settle;
        chk(radio_on, 0, "inactive sleep");
        wr(IDX_SLP, 0);
        ce <= 1'b0;
        clr;
        txr;
        slot(1'b0, 1'b0);
        ce <= 1'b1;
        slot(1'b0, 1'b0);
        settle;
        chk(cnt[2], 0, "frozen request");
        print_verdict;
    end
endmodule
